// *** verilog/pmcc_top.sv ***
// Purpose: hibernate entry and wake, regulator control, multiplier and clock dividers
// Assumes: the vco is modelled at sys_clk rate; derived clocks are enables plus levels
// Notes: regulator word survives hibernate, everything else restarts in the reset sequence
`timescale 1ns/1ns
module pmcc_top #(
  parameter int RST_CYC = pmcc_pkg::RSTSEQ_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic rtc_wake,
  input wire logic eth_wake,
  input wire logic can_wake,
  input wire logic vr_wr,
  input wire logic [pmcc_pkg::VR_W-1:0] vr_wdata,
  input wire logic div_wr,
  input wire logic [3:0] div_ssel,
  input wire logic [1:0] div_core_code,
  input wire logic mult_unlock,
  input wire logic mult_wr,
  input wire logic [pmcc_pkg::MSEL_W:0] mult_wdata,
  input wire logic sdram_ctl_sysclk_dis,
  input wire logic async_ctl_sysclk_dis,
  output logic core_clk_en,
  output logic core_clk_lvl,
  output logic sys_clk_en,
  output logic sys_clk_lvl,
  output logic ext_sysclk,
  output logic bufclk_en,
  output logic pins_hiz,
  output logic supply_on,
  output logic reg_bypass,
  output logic sdram_self_refresh,
  output logic boot_start,
  output logic in_hibernate,
  output logic [11:0] core_mv,
  output logic [pmcc_pkg::MSEL_W-1:0] mult_msel,
  output logic mult_half
);
  import pmcc_pkg::*;
  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    pmcc_state_t st; // operating state
    logic [3:0] sync1; // first sync stage, read only by sync2
    logic [3:0] sync2; // {can, eth, rtc, reset_n}
    logic [VR_W-1:0] vr; // regulator_control_reg
    logic [MSEL_W-1:0] msel; // multiplier select
    logic df; // input halving
    logic [3:0] ssel; // programmed system divider
    logic [3:0] cdiv; // programmed core divisor
    logic [3:0] act_s; // system divisor in use
    logic [3:0] act_c; // core divisor in use
    logic [3:0] scnt; // system period counter
    logic [3:0] ccnt; // core period counter
    logic [7:0] seq; // reset sequence counter
    logic core_en, core_lvl, sys_en, sys_lvl, ext_clk, hiz, boot, bufclk, supply, sref, hib;
    logic [11:0] mv;
  } pmcc_s_t;
  pmcc_s_t s_ff, nxt_s;
  // core divisor from its two-bit code
  function automatic logic [3:0] core_div_of(input logic [1:0] c);
    core_div_of = 4'h1 << c;
  endfunction
  // high for the first half of a period
  function automatic logic half_lvl(input logic [3:0] cnt, input logic [3:0] dv);
    half_lvl = ({1'b0, cnt} << 1) < {1'b0, dv};
  endfunction
  logic wake_any;
  logic pin_rst;
  assign pin_rst = ~s_ff.sync2[0];
  assign wake_any = s_ff.sync2[1] | s_ff.sync2[2] | s_ff.sync2[3] | pin_rst;
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = {can_wake, eth_wake, rtc_wake, reset_pin_n};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.boot = 1'b0;
    nxt_s.core_en = 1'b0;
    nxt_s.sys_en = 1'b0;
    // regulator word is written in any powered state
    if (vr_wr && s_ff.st != PMCC_HIBER) begin
      nxt_s.vr = vr_wdata;
    end
    unique case (s_ff.st)
      PMCC_RUN: begin
        // divider write takes effect at the next boundary
        if (div_wr && div_ssel != SSEL_ILLEGAL) begin
          nxt_s.ssel = div_ssel;
          nxt_s.cdiv = core_div_of(div_core_code);
        end
        // multiplier only changes under the unlock step
        if (mult_wr && mult_unlock) begin
          nxt_s.msel = mult_wdata[MSEL_W-1:0];
          nxt_s.df = mult_wdata[MULT_DF];
        end
        // system period counter, switches divisor only on wrap
        if (s_ff.scnt == s_ff.act_s - 4'h1) begin
          nxt_s.scnt = 4'h0;
          nxt_s.act_s = nxt_s.ssel;
          nxt_s.sys_en = 1'b1;
        end else begin
          nxt_s.scnt = s_ff.scnt + 4'h1;
        end
        // core period counter
        if (s_ff.ccnt == s_ff.act_c - 4'h1) begin
          nxt_s.ccnt = 4'h0;
          nxt_s.act_c = nxt_s.cdiv;
          nxt_s.core_en = 1'b1;
        end else begin
          nxt_s.ccnt = s_ff.ccnt + 4'h1;
        end
        nxt_s.sys_lvl = half_lvl(nxt_s.scnt, nxt_s.act_s);
        nxt_s.core_lvl = half_lvl(nxt_s.ccnt, nxt_s.act_c);
        nxt_s.ext_clk = nxt_s.sys_lvl & ~(sdram_ctl_sysclk_dis & async_ctl_sysclk_dis);
        // reset pin restarts; regulator_frequency_field 00 shuts the regulator
        if (pin_rst) begin
          nxt_s.st = PMCC_RSTSEQ;
          nxt_s.seq = 8'h0;
        end else if (vr_wr && vr_wdata[VR_REGULATOR_FREQUENCY_FIELD_LO +: 2] == REGULATOR_FREQUENCY_FIELD_OFF) begin
          nxt_s.st = PMCC_HIBER;
        end
      end
      PMCC_HIBER: begin
        // clocks stopped, pins floated, core state kept until the reset sequence restores it
        nxt_s.sys_lvl = 1'b0;
        nxt_s.core_lvl = 1'b0;
        nxt_s.ext_clk = 1'b0;
        nxt_s.hiz = 1'b1;
        if (wake_any) begin
          nxt_s.st = PMCC_RSTSEQ;
          nxt_s.seq = 8'h0;
        end
      end
      PMCC_RSTSEQ: begin
        // restore every register but the regulator word
        nxt_s.hiz = 1'b0;
        nxt_s.msel = MSEL_RESET;
        nxt_s.df = 1'b0;
        nxt_s.ssel = SSEL_RESET;
        nxt_s.cdiv = core_div_of(CDIV_RESET);
        nxt_s.act_s = SSEL_RESET;
        nxt_s.act_c = core_div_of(CDIV_RESET);
        nxt_s.scnt = 4'h0;
        nxt_s.ccnt = 4'h0;
        nxt_s.sys_lvl = 1'b0;
        nxt_s.core_lvl = 1'b0;
        nxt_s.ext_clk = 1'b0;
        if (pin_rst) begin
          nxt_s.seq = 8'h0; // held while the pin is low
        end else if (s_ff.seq == 8'(RST_CYC - 1)) begin
          nxt_s.st = PMCC_RUN;
          nxt_s.boot = 1'b1;
        end else begin
          nxt_s.seq = s_ff.seq + 8'h1;
        end
      end
      default: begin
        nxt_s.st = PMCC_RSTSEQ; // recover from an illegal code
        nxt_s.seq = 8'h0;
      end
    endcase
    nxt_s.mv = VBASE_MV + VSTEP_MV * {8'h0, nxt_s.vr[VR_VLEV_LO +: 4]};
    // status levels come from the next state, so the registered copy keeps step with it
    nxt_s.bufclk = ~nxt_s.vr[VR_BUFCLK_DIS] & ~nxt_s.hiz;
    nxt_s.supply = nxt_s.st != PMCC_HIBER;
    nxt_s.sref = nxt_s.vr[VR_SREF_HOLD] & (nxt_s.st != PMCC_RUN);
    nxt_s.hib = nxt_s.st == PMCC_HIBER;
  end
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.st <= PMCC_RSTSEQ;
      s_ff.sync1 <= 4'h1;
      s_ff.sync2 <= 4'h1;
      s_ff.vr <= VR_RESET;
      s_ff.msel <= MSEL_RESET;
      s_ff.ssel <= SSEL_RESET;
      s_ff.cdiv <= 4'h1;
      s_ff.act_s <= SSEL_RESET;
      s_ff.act_c <= 4'h1;
      s_ff.mv <= VBASE_MV;
      s_ff.bufclk <= 1'b1;
      s_ff.supply <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
  // ---------------------------------------------------------------
  // outputs, all straight from the state record
  // ---------------------------------------------------------------
  assign core_clk_en = s_ff.core_en;
  assign core_clk_lvl = s_ff.core_lvl;
  assign sys_clk_en = s_ff.sys_en;
  assign sys_clk_lvl = s_ff.sys_lvl;
  assign ext_sysclk = s_ff.ext_clk;
  assign bufclk_en = s_ff.bufclk;
  assign pins_hiz = s_ff.hiz;
  assign supply_on = s_ff.supply;
  assign reg_bypass = s_ff.vr[VR_BYPASS];
  assign sdram_self_refresh = s_ff.sref;
  assign boot_start = s_ff.boot;
  assign in_hibernate = s_ff.hib;
  assign core_mv = s_ff.mv;
  assign mult_msel = s_ff.msel;
  assign mult_half = s_ff.df;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_hib_entry;
    s_ff.st == PMCC_RUN && !pin_rst && vr_wr && vr_wdata[1:0] == 2'h0 |=> in_hibernate;
  endproperty
  a_hib_entry: assert property (p_hib_entry) else $error("regulator_frequency_field 00 did not hibernate");
  property p_hib_quiet;
    in_hibernate |-> ##1 (!sys_clk_en && !core_clk_en && !ext_sysclk);
  endproperty
  a_hib_quiet: assert property (p_hib_quiet) else $error("clock ran in hibernate");
  property p_hib_hiz;
    in_hibernate && $past(in_hibernate) |-> pins_hiz && !bufclk_en;
  endproperty
  a_hib_hiz: assert property (p_hib_hiz) else $error("pins driven in hibernate");
  property p_wake;
    in_hibernate && (s_ff.sync2[2] || s_ff.sync2[3]) |=> s_ff.st == PMCC_RSTSEQ;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_boot;
    s_ff.st == PMCC_RSTSEQ && !pin_rst && s_ff.seq == 8'(RST_CYC - 1) |=> boot_start;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot after reset sequence");
  property p_seq_bound;
    s_ff.st == PMCC_RSTSEQ |-> s_ff.seq < 8'(RST_CYC); // sequence count never overruns
  endproperty
  a_seq_bound: assert property (p_seq_bound) else $error("reset sequence overran");
  property p_vr_kept;
    in_hibernate ##1 s_ff.st == PMCC_RSTSEQ |-> $stable(s_ff.vr);
  endproperty
  a_vr_kept: assert property (p_vr_kept) else $error("regulator word lost");
  property p_reinit;
    boot_start |-> mult_msel == 6'h0a && s_ff.ssel == 4'h5;
  endproperty
  a_reinit: assert property (p_reinit) else $error("registers not reset on wake");
  property p_mv;
    !$past(rst) |-> core_mv == 12'h320 + 12'h032 * {8'h0, s_ff.vr[7:4]};
  endproperty
  a_mv: assert property (p_mv) else $error("voltage step wrong");
  property p_ssel_zero;
    s_ff.st == PMCC_RUN && div_wr && div_ssel == 4'h0 |=> $stable(s_ff.ssel);
  endproperty
  a_ssel_zero: assert property (p_ssel_zero) else $error("illegal divide taken");
  property p_boundary;
    $changed(s_ff.act_s) && s_ff.st == PMCC_RUN && $past(s_ff.st) == PMCC_RUN |-> sys_clk_en;
  endproperty
  a_boundary: assert property (p_boundary) else $error("divisor switched mid period");
  property p_core_divider_select;
    s_ff.st == PMCC_RUN && !pin_rst && div_wr && div_ssel != 4'h0 |=>
      s_ff.cdiv == (4'h1 << $past(div_core_code));
  endproperty
  a_core_divider_select: assert property (p_core_divider_select) else $error("core divisor wrong");
  property p_mult_guard;
    s_ff.st == PMCC_RUN && mult_wr && !mult_unlock |=> $stable(mult_msel);
  endproperty
  a_mult_guard: assert property (p_mult_guard) else $error("multiplier changed unguarded");
  c_hib: cover property (in_hibernate ##[1:50] boot_start);
  c_div: cover property (s_ff.st == PMCC_RUN && div_wr ##[1:30] $changed(s_ff.act_s));
  c_mult: cover property (mult_wr && mult_unlock);
endmodule

// *** pkg/pmcc_pkg.sv ***
// Purpose: constants and types for the power mode and clock control block
// Assumes: one 20 MHz clock standing in for the input clock
// Notes: field positions of the regulator and multiplier write words, divider reset and illegal codes
package pmcc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000; // sys_clk rate
  localparam int RSTSEQ_NS = 2000; // length of the hardware reset sequence
  localparam int RSTSEQ_CYC = (RSTSEQ_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // ---------------------------------------------------------------
  // regulator control word layout
  // ---------------------------------------------------------------
  localparam int VR_W = 16;
  localparam int VR_REGULATOR_FREQUENCY_FIELD_LO = 0; // two-bit regulator frequency field
  localparam int VR_VLEV_LO = 4; // four-bit voltage level field
  localparam int VR_BYPASS = 12; // regulator off and bypassed
  localparam int VR_SREF_HOLD = 13; // sdram self refresh hold
  localparam int VR_BUFCLK_DIS = 14; // buffered clock output off
  localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_OFF = 2'h0; // shuts the regulator off
  localparam logic [VR_W-1:0] VR_RESET = 16'h00b3;
  localparam logic [11:0] VSTEP_MV = 12'h032; // 50 mV per level step
  localparam logic [11:0] VBASE_MV = 12'h320; // level zero voltage
  // ---------------------------------------------------------------
  // multiplier and dividers
  // ---------------------------------------------------------------
  localparam int MSEL_W = 6; // 0 encodes 64
  localparam int MULT_DF = 6; // halve input before multiplying
  localparam logic [MSEL_W-1:0] MSEL_RESET = 6'h0a; // 10x
  localparam logic [3:0] SSEL_RESET = 4'h5;
  localparam logic [1:0] CDIV_RESET = 2'h0;
  localparam logic [3:0] SSEL_ILLEGAL = 4'h0;
  // ---------------------------------------------------------------
  // operating states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PMCC_RUN = 2'b00,
    PMCC_HIBER = 2'b01,
    PMCC_RSTSEQ = 2'b10
  } pmcc_state_t;
endpackage

// *** tb/pmcc_bench.sv ***
// Purpose: self-checking bench for the power mode and clock control block
// Assumes: short reset sequence; inputs driven 5 ns after the rising edge
// Notes: the driver notes expectations in a queue, a monitor pops and compares them
`timescale 1ns/1ns
module pmcc_bench;
  import pmcc_pkg::*;
  localparam int RSTC = 4; // shortened reset sequence
  // ---------------------------------------------------------------
  // design inputs and outputs
  // ---------------------------------------------------------------
  logic sys_clk = 0, rst = 1, reset_pin_n = 1, rtc_wake = 0, eth_wake = 0, can_wake = 0;
  logic vr_wr = 0, div_wr = 0, mult_unlock = 0, mult_wr = 0;
  logic sdram_ctl_sysclk_dis = 0, async_ctl_sysclk_dis = 0;
  logic [VR_W-1:0] vr_wdata = '0;
  logic [3:0] div_ssel = 4'h1;
  logic [1:0] div_core_code = 2'h0;
  logic [MSEL_W:0] mult_wdata = '0;
  logic core_clk_en, core_clk_lvl, sys_clk_en, sys_clk_lvl, ext_sysclk, bufclk_en, pins_hiz;
  logic supply_on, reg_bypass, sdram_self_refresh, boot_start, in_hibernate, mult_half;
  logic [11:0] core_mv;
  logic [MSEL_W-1:0] mult_msel;
  // ---------------------------------------------------------------
  // bench state
  // ---------------------------------------------------------------
  typedef struct {string nm; logic [15:0] exp;} pmcc_note_t;
  pmcc_note_t notes[$]; // expectations waiting for the monitor
  event look; // a result is ready to be compared
  logic [15:0] meas; // measured value for derived checks
  logic [31:0] rng = 32'h0000a8ed; // xorshift state
  int errors = 0, check_count = 0;
  int p, lv;
  logic [31:0] r;
  always #25 sys_clk = ~sys_clk; // 20 MHz
  pmcc_top #(.RST_CYC(RSTC)) pmcc_top_inst (.sys_clk(sys_clk), .rst(rst),
    .reset_pin_n(reset_pin_n), .rtc_wake(rtc_wake), .eth_wake(eth_wake), .can_wake(can_wake),
    .vr_wr(vr_wr), .vr_wdata(vr_wdata), .div_wr(div_wr), .div_ssel(div_ssel),
    .div_core_code(div_core_code), .mult_unlock(mult_unlock), .mult_wr(mult_wr),
    .mult_wdata(mult_wdata), .sdram_ctl_sysclk_dis(sdram_ctl_sysclk_dis),
    .async_ctl_sysclk_dis(async_ctl_sysclk_dis),
    .core_clk_en(core_clk_en), .core_clk_lvl(core_clk_lvl), .sys_clk_en(sys_clk_en),
    .sys_clk_lvl(sys_clk_lvl), .ext_sysclk(ext_sysclk), .bufclk_en(bufclk_en),
    .pins_hiz(pins_hiz), .supply_on(supply_on), .reg_bypass(reg_bypass),
    .sdram_self_refresh(sdram_self_refresh), .boot_start(boot_start),
    .in_hibernate(in_hibernate), .core_mv(core_mv), .mult_msel(mult_msel),
    .mult_half(mult_half));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // picks the output named by a note
  function automatic logic [15:0] seen(string nm);
    case (nm)
      "core_mv": return 16'(core_mv);
      "mult_msel": return 16'(mult_msel);
      "mult_half": return 16'(mult_half);
      "bufclk_en": return 16'(bufclk_en);
      "reg_bypass": return 16'(reg_bypass);
      "sdram_self_refresh": return 16'(sdram_self_refresh);
      "in_hibernate": return 16'(in_hibernate);
      "supply_on": return 16'(supply_on);
      "pins_hiz": return 16'(pins_hiz);
      "sys_clk_en": return 16'(sys_clk_en);
      "core_clk_en": return 16'(core_clk_en);
      default: return meas;
    endcase
  endfunction
  // next xorshift value
  task automatic rnd(output logic [31:0] v);
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    v = rng;
  endtask
  // one clock, then a small settling delay
  task automatic tick();
    @(posedge sys_clk);
    #5;
  endtask
  // queue an expectation and hand it to the monitor
  task automatic check(string nm, logic [15:0] exp);
    notes.push_back('{nm, exp});
    ->look;
    #0; // let the monitor compare before the caller moves on, without shifting time
  endtask
  task automatic vr_write(logic [15:0] w);
    vr_wdata = w;
    vr_wr = 1;
    tick();
    vr_wr = 0;
  endtask
  task automatic div_write(logic [3:0] s, logic [1:0] c);
    div_ssel = s;
    div_core_code = c;
    div_wr = 1;
    tick();
    div_wr = 0;
  endtask
  task automatic mult_write(logic [6:0] d, logic u);
    mult_wdata = d;
    mult_unlock = u;
    mult_wr = 1;
    tick();
    mult_wr = 0;
    mult_unlock = 0;
  endtask
  // bounded wait for the boot pulse; meas is 1 when it came
  task automatic wait_boot();
    meas = 0;
    for (int n = 0; n < 200 && meas == 0; n++) begin
      tick();
      if (boot_start === 1'b1) meas = 1;
    end
  endtask
  // cycles between two enable pulses of the chosen derived clock
  task automatic per(input bit core, output int q);
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 40 && (core ? core_clk_en : sys_clk_en) !== 1'b1; n++) tick();
      q = 0;
      do begin
        tick();
        q++;
      end while ((core ? core_clk_en : sys_clk_en) !== 1'b1 && q < 40);
    end
    meas = 16'(q);
  endtask
  // ---------------------------------------------------------------
  // monitor: compares the oldest note with what the outputs show
  // ---------------------------------------------------------------
  initial forever begin
    pmcc_note_t n;
    @(look);
    n = notes.pop_front();
    check_count++;
    if (seen(n.nm) !== n.exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n.nm, n.exp, seen(n.nm));
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs only a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    #5 rst = 0;
    wait_boot();
    check("boot", 16'h1);
    check("bufclk_en", 16'h1);
    check("mult_msel", 16'(MSEL_RESET));
    per(0, p);
    check("sys_period", 16'(SSEL_RESET));
    // voltage level, bypass, buffered clock and self refresh bits
    for (int i = 0; i < 6; i++) begin
      rnd(r);
      vr_write({1'b0, r[1], r[2], r[3], 4'h0, r[7:4], 4'h3});
      tick();
      check("core_mv", 16'(VBASE_MV + VSTEP_MV * 12'(r[7:4])));
      check("reg_bypass", 16'(r[3]));
      check("bufclk_en", 16'(!r[1]));
      check("sdram_self_refresh", 16'h0);
    end
    // every core divider code with a random system divider, changed on the fly
    for (int c = 0; c < 4; c++) begin
      rnd(r);
      lv = (r[3:0] == 0) ? 15 : r[3:0];
      div_write(4'(lv), 2'(c));
      per(1, p);
      check("core_period", 16'(1 << c));
      per(0, p);
      check("sys_period", 16'(lv));
    end
    div_write(4'h0, 2'h0);
    per(0, p);
    check("sys_period", 16'(lv));
    // multiplier: refused without the unlock, taken with it
    lv = MSEL_RESET; // value the multiplier should still hold
    for (int i = 0; i < 4; i++) begin
      rnd(r);
      mult_write(7'(~r), 0);
      tick();
      check("mult_msel", 16'(lv));
      mult_write(7'(r), 1);
      tick();
      check("mult_msel", 16'(r[5:0]));
      check("mult_half", 16'(r[6]));
      lv = r[5:0];
    end
    // external clock pin: off only when both disables are set
    sdram_ctl_sysclk_dis = 1;
    async_ctl_sysclk_dis = 1;
    tick();
    meas = 0;
    repeat (16) begin
      tick();
      if (ext_sysclk !== 1'b0) meas++;
    end
    check("ext_off", 16'h0);
    async_ctl_sysclk_dis = 0;
    tick();
    meas = 0;
    p = 0;
    repeat (16) begin
      tick();
      if (ext_sysclk !== sys_clk_lvl) meas++;
      if (core_clk_lvl === 1'b1) p++;
    end
    check("ext_follow", 16'h0);
    // core divider is 8 here: two whole periods, high for half of each
    meas = 16'(p);
    check("core_high", 16'h8);
    // hibernate, then wake by each source in turn
    for (int k = 0; k < 4; k++) begin
      rnd(r);
      lv = r[3:0];
      mult_write(7'h03, 1);
      // buffered clock off, self refresh hold on, level lv, regulator off
      vr_write({3'b011, 5'h0, 4'(lv), 4'h0});
      tick();
      check("in_hibernate", 16'h1);
      check("supply_on", 16'h0);
      check("sys_clk_en", 16'h0);
      check("core_clk_en", 16'h0);
      check("pins_hiz", 16'h1);
      check("sdram_self_refresh", 16'h1);
      vr_write(16'h00f3);
      case (k)
        0: rtc_wake = 1;
        1: eth_wake = 1;
        2: can_wake = 1;
        default: reset_pin_n = 0;
      endcase
      repeat (4) tick();
      {rtc_wake, eth_wake, can_wake, reset_pin_n} = 4'h1;
      wait_boot();
      check("boot", 16'h1);
      check("pins_hiz", 16'h0);
      check("core_mv", 16'(VBASE_MV + VSTEP_MV * 12'(lv)));
      check("mult_msel", 16'(MSEL_RESET));
      per(0, p);
      check("sys_period", 16'(SSEL_RESET));
    end
    // reset pin while running restarts through the reset sequence
    mult_write(7'h03, 1);
    reset_pin_n = 0;
    repeat (4) tick();
    reset_pin_n = 1;
    wait_boot();
    check("boot", 16'h1);
    check("mult_msel", 16'(MSEL_RESET));
    tally_and_finish();
  end
endmodule
